/* File: hw/hct_timing_regs.sv */
/*
 * Horizontal display timing with indexed register access over two I/O ports.
 * Assumes one clock per character time from the sequencer_unit, and a host
 * that writes the index before accessing the data port.
 */
// Contract
// - Six-bit index register selects which timing register the data port reaches.
// - Ports decode at mono or color addresses per miscellaneous output bit 0.
// - An 8-bit total sets line length; software subtracts 5 VGA, 2 EGA.
// - Character time comes from the sequencer_unit clocking setting, not here.
// - Display enable ends after counter passes display end; end plus one characters.
// - Blanking starts when the counter equals blank start.
// - EGA blanking ends on first 5-bit low-bits match after start.
// - VGA blanking end compares 6 bits, top bit from sync-end bit 7.
// - Blank-end bits 6:5 skew display enable by 0 to 3 characters.
// - Blank-end bit 7 is a test bit; one means normal operation.
// - Retrace starts when the counter equals sync start.
// - Sync-end bits 6:5 skew the sync output by 0 to 3 characters.
// - Sync ends on first 5-bit low-bits match after sync starts.
// - When protection is active host writes leave the six registers unchanged.
`timescale 1ns/1ns
`include "hct_defs.svh"
module hct_timing_regs #(
    parameter int COUNT_W = 8
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [15:0]       ioAddr,
    input  wire logic              ioWrite,
    input  wire logic              ioRead,
    input  wire logic [7:0]        ioWriteData,
    output logic      [7:0]        ioReadData,
    output logic                   ioReadHit,
    input  wire logic              colorSelect,
    input  wire hct_pkg::hct_mode_t timingMode,
    input  wire logic              writeProtect,
    output logic                   displayEnable,
    output logic                   blanking,
    output logic                   horizontalSync,
    output logic [COUNT_W-1:0]     charCount
);
    logic [5:0]         index_q;
    logic [7:0]         lineTotal_q;
    logic [7:0]         dispEnd_q;
    logic [7:0]         blankStart_q;
    logic [7:0]         blankEnd_q;
    logic [7:0]         retraceStart_q;
    logic [7:0]         retraceEnd_q;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic               dispEn_q;
    logic               blank_q;
    logic               sync_q;
    logic               syncRaw;
    logic               dispRaw;
    logic               testNormal;
    logic [7:0]         readData_d;
    logic               indexHit;
    logic               dataHit;
    logic [5:0]         blankEndValue;
    logic [5:0]         blankEndCount;

    function automatic logic portMatch(
        input logic [15:0] addr,
        input logic        color,
        input logic [15:0] mono,
        input logic [15:0] colr
    );
        portMatch = color ? (addr == colr) : (addr == mono);
    endfunction

    assign indexHit = portMatch(ioAddr, colorSelect, `HCT_PORT_MONO_INDEX,
                                `HCT_PORT_COLOR_INDEX);
    assign dataHit  = portMatch(ioAddr, colorSelect, `HCT_PORT_MONO_DATA,
                                `HCT_PORT_COLOR_DATA);

    always_ff @(posedge clock)
    begin
        if (reset)
            index_q <= 6'h00;
        else if (ioWrite && indexHit)
            index_q <= ioWriteData[`HCT_INDEX_MSB:0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            lineTotal_q    <= `HCT_RESET_BYTE;
            dispEnd_q      <= `HCT_RESET_BYTE;
            blankStart_q   <= `HCT_RESET_BYTE;
            blankEnd_q     <= `HCT_RESET_BYTE;
            retraceStart_q <= `HCT_RESET_BYTE;
            retraceEnd_q   <= `HCT_RESET_BYTE;
        end
        else if (ioWrite && dataHit && !writeProtect)
        begin
            unique case (index_q)
                `HCT_IDX_LINE_TOTAL:    lineTotal_q    <= ioWriteData;
                `HCT_IDX_DISP_END:      dispEnd_q      <= ioWriteData;
                `HCT_IDX_BLANK_START:   blankStart_q   <= ioWriteData;
                `HCT_IDX_BLANK_END:     blankEnd_q     <= ioWriteData;
                `HCT_IDX_RETRACE_START: retraceStart_q <= ioWriteData;
                `HCT_IDX_RETRACE_END:   retraceEnd_q   <= ioWriteData;
                default:                ;
            endcase
        end
    end

    always_comb
    begin
        readData_d = 8'h00;
        if (indexHit)
            readData_d = {2'b00, index_q};
        else
        begin
            unique case (index_q)
                `HCT_IDX_LINE_TOTAL:    readData_d = lineTotal_q;
                `HCT_IDX_DISP_END:      readData_d = dispEnd_q;
                `HCT_IDX_BLANK_START:   readData_d = blankStart_q;
                `HCT_IDX_BLANK_END:     readData_d = blankEnd_q;
                `HCT_IDX_RETRACE_START: readData_d = retraceStart_q;
                `HCT_IDX_RETRACE_END:   readData_d = retraceEnd_q;
                default:                readData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ioReadData <= 8'h00;
            ioReadHit  <= 1'b0;
        end
        else
        begin
            ioReadHit  <= ioRead && (indexHit || dataHit);
            ioReadData <= (ioRead && (indexHit || dataHit)) ? readData_d : 8'h00;
        end
    end

    // One clock is one character time; its width is set by the sequencer_unit.
    assign count_d = (count_q == COUNT_W'(lineTotal_q)) ? '0 : count_q + 1'b1;

    always_ff @(posedge clock)
    begin
        if (reset)
            count_q <= '0;
        else
            count_q <= count_d;
    end

    assign testNormal = blankEnd_q[`HCT_TEST_BIT];

    always_ff @(posedge clock)
    begin
        if (reset)
            dispEn_q <= 1'b1;
        else if (count_d == '0)
            dispEn_q <= 1'b1;
        else if (count_q == COUNT_W'(dispEnd_q))
            dispEn_q <= 1'b0;
    end

    assign blankEndValue = (timingMode == hct_pkg::HCT_MODE_VGA)
        ? {retraceEnd_q[`HCT_BLANK_END_HI_BIT], blankEnd_q[`HCT_END5_MSB:0]}
        : {1'b0, blankEnd_q[`HCT_END5_MSB:0]};
    assign blankEndCount = (timingMode == hct_pkg::HCT_MODE_VGA)
        ? count_q[5:0]
        : {1'b0, count_q[4:0]};

    always_ff @(posedge clock)
    begin
        if (reset)
            blank_q <= 1'b0;
        else if (!blank_q && count_q == COUNT_W'(blankStart_q))
            blank_q <= 1'b1;
        else if (blank_q && blankEndCount == blankEndValue)
            blank_q <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            sync_q <= 1'b0;
        else if (!sync_q && count_q == COUNT_W'(retraceStart_q))
            sync_q <= 1'b1;
        else if (sync_q && count_q[4:0] == retraceEnd_q[`HCT_END5_MSB:0])
            sync_q <= 1'b0;
    end

    assign dispRaw = dispEn_q && testNormal;
    assign syncRaw = sync_q && testNormal;

    hct_skew_delay #(
        .MAX_SKEW (3)
    ) uDispSkew (
        .clock    (clock),
        .reset    (reset),
        .levelIn  (dispRaw),
        .skewSel  (blankEnd_q[`HCT_SKEW_MSB:`HCT_SKEW_LSB]),
        .levelOut (displayEnable)
    );

    hct_skew_delay #(
        .MAX_SKEW (3)
    ) uSyncSkew (
        .clock    (clock),
        .reset    (reset),
        .levelIn  (syncRaw),
        .skewSel  (retraceEnd_q[`HCT_SKEW_MSB:`HCT_SKEW_LSB]),
        .levelOut (horizontalSync)
    );

    assign blanking  = blank_q || !testNormal;
    assign charCount = count_q;
endmodule // hct_timing_regs

/* File: hw/hct_defs.svh */
/*
 * Register indices, field positions and I/O port addresses for the horizontal timing block.
 * Assumes inclusion by bare name from the design and testbench modules.
 */
`ifndef HCT_DEFS_SVH
`define HCT_DEFS_SVH

`define HCT_IDX_LINE_TOTAL     6'h00
`define HCT_IDX_DISP_END       6'h01
`define HCT_IDX_BLANK_START    6'h02
`define HCT_IDX_BLANK_END      6'h03
`define HCT_IDX_RETRACE_START  6'h04
`define HCT_IDX_RETRACE_END    6'h05
`define HCT_INDEX_MSB          5
`define HCT_SKEW_MSB           6
`define HCT_SKEW_LSB           5
`define HCT_END5_MSB           4
`define HCT_TEST_BIT           7
`define HCT_BLANK_END_HI_BIT   7
`define HCT_PORT_MONO_INDEX    16'h03B4
`define HCT_PORT_MONO_DATA     16'h03B5
`define HCT_PORT_COLOR_INDEX   16'h03D4
`define HCT_PORT_COLOR_DATA    16'h03D5
`define HCT_RESET_BYTE         8'h00

`endif

/* File: hw/hct_pkg.sv */
/*
 * Types shared by the horizontal timing block.
 * Assumes the constants header is on the include path.
 */
package hct_pkg;
    typedef enum logic [0:0]
    {
        HCT_MODE_EGA = 1'b0,
        HCT_MODE_VGA = 1'b1
    } hct_mode_t;
endpackage

/* File: hw/hct_skew_delay.sv */
/*
 * Delays a single level by 0 to 3 clocks, selected at run time.
 * Assumes the select is steady while the delayed level is in use.
 */
`timescale 1ns/1ns
module hct_skew_delay #(
    parameter int MAX_SKEW = 3
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       levelIn,
    input  wire logic [1:0] skewSel,
    output logic            levelOut
);
    logic [MAX_SKEW:0] tap;

    assign tap[0] = levelIn;

    genvar g;
    generate
        for (g = 1; g <= MAX_SKEW; g++)
        begin : gStage
            logic stage_q;
            always_ff @(posedge clock)
            begin
                if (reset)
                    stage_q <= 1'b0;
                else
                    stage_q <= tap[g-1];
            end
            assign tap[g] = stage_q;
        end
    endgenerate

    assign levelOut = tap[skewSel];
endmodule // hct_skew_delay

/* File: tb/hct_monitor.sv */
/* Checker for the horizontal timing block, with its bind.
   Assumes it sees only the block's ports and mirrors the register writes. */
`timescale 1ns/1ns
`include "hct_defs.svh"
module hct_monitor #(
    parameter int COUNT_W = 8
) (
    input wire logic               clock,
    input wire logic               reset,
    input wire logic [15:0]        ioAddr,
    input wire logic               ioWrite,
    input wire logic               ioRead,
    input wire logic [7:0]         ioWriteData,
    input wire logic [7:0]         ioReadData,
    input wire logic               ioReadHit,
    input wire logic               colorSelect,
    input wire hct_pkg::hct_mode_t timingMode,
    input wire logic               writeProtect,
    input wire logic               displayEnable,
    input wire logic               blanking,
    input wire logic               horizontalSync,
    input wire logic [COUNT_W-1:0] charCount
);
    logic [5:0]  idx_q;
    logic [7:0]  tim_q [6];
    wire  [15:0] ip = colorSelect ? `HCT_PORT_COLOR_INDEX : `HCT_PORT_MONO_INDEX;
    wire  [15:0] dp = ip + 16'h0001;
    wire         hitAddr = ioAddr == ip || ioAddr == dp;
    wire  [7:0]  sel = (idx_q < 6'h06) ? tim_q[idx_q] : 8'h00;
    wire         atTot = charCount == tim_q[0];
    wire  [1:0]  ssk = tim_q[5][6:5];
    wire         bem = charCount[4:0] == tim_q[3][4:0]
                       && (timingMode == hct_pkg::HCT_MODE_EGA || charCount[5] == tim_q[5][7]);
    always_ff @(posedge clock)
        if (reset)
            idx_q <= 6'h00;
        else if (ioWrite && ioAddr == ip)
            idx_q <= ioWriteData[5:0];
    always_ff @(posedge clock)
        if (reset)
            tim_q <= '{default: 8'h00};
        else if (ioWrite && ioAddr == dp && !writeProtect && idx_q < 6'h06)
            tim_q[idx_q] <= ioWriteData;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_idx_rd; ioRead && ioAddr == ip; endsequence
    sequence s_dat_rd; ioRead && ioAddr == dp; endsequence
    property p_hit; ioRead |=> ioReadHit == $past(hitAddr); endproperty
    a_hit: assert property (p_hit) else $error("read hit wrong");
    property p_idx; s_idx_rd |=> ioReadData == {2'b00, $past(idx_q)}; endproperty
    a_idx: assert property (p_idx) else $error("index read wrong");
    property p_dat; s_dat_rd |=> ioReadData == $past(sel); endproperty
    a_dat: assert property (p_dat) else $error("data read wrong");
    property p_cnt; charCount == ($past(atTot) ? 8'h00 : $past(charCount) + 8'h01); endproperty
    a_cnt: assert property (p_cnt) else $error("counter step wrong");
    property p_bs; charCount == tim_q[2] && tim_q[3][7] |=> blanking; endproperty
    a_bs: assert property (p_bs) else $error("blank start wrong");
    property p_be; blanking && bem && tim_q[3][7] && charCount != tim_q[2] |=> !blanking; endproperty
    a_be: assert property (p_be) else $error("blank end wrong");
    property p_sk; $rose(horizontalSync) && ssk == 2'b11 && $past(ssk, 4) == 2'b11
        |-> $past(charCount, 4) == tim_q[4]; endproperty
    a_sk: assert property (p_sk) else $error("sync skew wrong");
    property p_se; horizontalSync && ssk == 2'b00 && charCount[4:0] == tim_q[5][4:0]
        && charCount != tim_q[4] |=> !horizontalSync; endproperty
    a_se: assert property (p_se) else $error("sync end wrong");
    property p_tst; !tim_q[3][7] |-> blanking; endproperty
    a_tst: assert property (p_tst) else $error("test bit not blanking");
endmodule // hct_monitor
bind hct_timing_regs hct_monitor #(.COUNT_W(COUNT_W)) mon (.clock, .reset, .ioAddr,
    .ioWrite, .ioRead, .ioWriteData, .ioReadData, .ioReadHit, .colorSelect, .timingMode,
    .writeProtect, .displayEnable, .blanking, .horizontalSync, .charCount);

/* File: tb/hct_host.sv */
/* Host model making indexed I/O accesses.
   Assumes one caller process and a misc output bit 0 on colorSelect. */
`timescale 1ns/1ns
`include "hct_defs.svh"
module hct_host (
    input wire logic    clock,
    input wire logic    colorSelect,
    output logic [15:0] ioAddr = 16'h0000,
    output logic        ioWrite = 1'b0,
    output logic        ioRead = 1'b0,
    output logic [7:0]  ioWriteData = 8'h00
);
    wire [15:0] base = colorSelect ? `HCT_PORT_COLOR_INDEX : `HCT_PORT_MONO_INDEX;
    task io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        ioAddr <= a;
        ioWriteData <= d;
        ioWrite <= w;
        ioRead <= !w;
        @(posedge clock);
        ioWrite <= 1'b0;
        ioRead <= 1'b0;
        ioWriteData <= ~d;
    endtask
    task setr(input logic [5:0] i, input logic [7:0] v);
        io(1'b1, base, {2'b00, i});
        io(1'b1, base + 16'h0001, v);
    endtask
    task getr(input logic [5:0] i);
        io(1'b1, base, {2'b00, i});
        io(1'b0, base + 16'h0001, 8'h00);
    endtask
endmodule // hct_host

/* File: tb/tb_hct_timing_regs.sv */
/* Self-checking bench for the horizontal timing block.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ns
`include "hct_defs.svh"
module tb_hct_timing_regs;
    logic               clock = 1'b0;
    logic               reset = 1'b1;
    logic               colorSelect = 1'b1;
    logic               writeProtect = 1'b0;
    hct_pkg::hct_mode_t timingMode = hct_pkg::HCT_MODE_EGA;
    logic [15:0]        ioAddr;
    logic               ioWrite, ioRead, ioReadHit;
    logic               displayEnable, blanking, horizontalSync;
    logic [7:0]         ioWriteData, ioReadData, charCount, p0;
    logic [7:0]         q [$];
    logic [7:0]         v [6];
    int                 n_fail = 0;
    int                 comparisons = 0;
    int                 i, k, len;
    always #5 clock = ~clock;
    hct_host host (.clock, .colorSelect, .ioAddr, .ioWrite, .ioRead, .ioWriteData);
    hct_timing_regs #(.COUNT_W(8)) uut (.clock, .reset, .ioAddr, .ioWrite, .ioRead,
        .ioWriteData, .ioReadData, .ioReadHit, .colorSelect, .timingMode, .writeProtect,
        .displayEnable, .blanking, .horizontalSync, .charCount);
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task waitDe(input logic lv);
        int t;
        for (t = 0; t < 300 && displayEnable !== lv; t++)
            @(negedge clock);
        if (t == 300)
        begin
            n_fail++;
            test_done;
        end
    endtask
    task waitHs(input logic lv);
        int t;
        for (t = 0; t < 300 && horizontalSync !== lv; t++)
            @(negedge clock);
        if (t == 300)
        begin
            n_fail++;
            test_done;
        end
    endtask
    task rd(input logic [5:0] r, input logic [7:0] e);
        q.push_back(e);
        host.getr(r);
    endtask
    always @(negedge clock)
        if (ioReadHit === 1'b1)
            chk("readData", q.size() > 0 ? q.pop_front() : 8'hxx, ioReadData);
    initial
    begin
        void'($urandom(32576));
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            v[i] = 8'($urandom) & 8'h7f;
            host.setr(6'(i), v[i]);
        end
        writeProtect <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            host.setr(6'(i), ~v[i]);
            rd(6'(i), v[i]);
        end
        writeProtect <= 1'b0;
        rd(6'd7, 8'h00);
        q.push_back(8'h05);
        host.io(1'b1, host.base, 8'hc5);
        host.io(1'b0, host.base, 8'h00);
        colorSelect <= 1'b0;
        rd(6'd5, v[5]);
        host.io(1'b0, `HCT_PORT_COLOR_DATA, 8'h00);
        host.setr(6'd0, 8'd49);
        host.setr(6'd1, 8'd39);
        host.setr(6'd2, 8'd41);
        host.setr(6'd4, 8'd43);
        for (k = 0; k < 8; k++)
        begin
            timingMode <= hct_pkg::hct_mode_t'(k / 4);
            host.setr(6'd5, {k < 4, 2'(k), 5'd15});
            host.setr(6'd3, {1'b1, 2'(k), 5'd14});
            repeat (120) @(posedge clock);
            @(negedge clock);
            waitDe(1'b0);
            waitDe(1'b1);
            if (k % 4 == 0)
                p0 = charCount;
            chk("enableSkew", 8'(k % 4), charCount - p0);
            for (len = 0; len < 300 && displayEnable === 1'b1; len++)
                @(negedge clock);
            chk("enableLength", 8'd40, 8'(len));
            waitHs(1'b1);
            chk("syncStart", 8'd44 + 8'(k % 4), charCount);
            for (len = 0; len < 300 && horizontalSync === 1'b1; len++)
                @(negedge clock);
            chk("syncLength", 8'd4, 8'(len));
        end
        chk("pendingReads", 8'h00, 8'(q.size()));
        test_done;
    end
endmodule // tb_hct_timing_regs
